// >>> verilog/asd_pkg.sv
package asd_pkg;
  // ---------------------------------------------------------------
  // register map (printed offsets are not all word multiples, so
  // they are indices and the byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_RESULT_HIGH_IDX  = 12'hF72;
  localparam logic [11:0] REG_RESULT_LOW_IDX   = 12'hF73;
  localparam logic [11:0] REG_SCAN_CTRL_IDX    = 12'hFBE;
  localparam logic [11:0] REG_DEST_ADDR_IDX    = 12'hFBD;
  localparam logic [11:0] REG_IRQ_STATUS_IDX   = 12'hFC0;
  localparam logic [11:0] REG_IRQ_MASK_IDX     = 12'hFC1;
  localparam int          ADDR_W               = 14;

  // ---------------------------------------------------------------
  // control field layout and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_EN_BIT          = 7;
  localparam int          CTRL_IRQ_BIT         = 6;
  localparam int          CTRL_CNT_LSB         = 0;
  localparam int          CTRL_CNT_W           = 4;
  localparam logic [7:0]  CTRL_RESET           = 8'h00;
  localparam logic [7:0]  CTRL_WMASK           = 8'hCF;
  localparam logic [3:0]  CNT_MAX_CODE         = 4'hB;
  localparam logic [6:0]  DEST_RESET           = 7'h00;
  localparam logic [1:0]  IRQ_MASK_RESET       = 2'h3;

  // status bits: scan done, reserved count code seen
  localparam int          ST_DONE_BIT          = 0;
  localparam int          ST_BADCNT_BIT        = 1;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY            = 2'h0;
  localparam logic [1:0]  RESP_SLVERR          = 2'h2;

  typedef enum logic [1:0] {
    ASD_IDLE,
    ASD_CONVERT,
    ASD_XFER_HI,
    ASD_XFER_LO
  } asd_state_t;
endpackage

// >>> verilog/asd_scan_dma.sv
`timescale 1ns/10ps
// How it works
// - enable bit low stops the channel and forces the input count back to zero.
// - interrupt bit high raises an interrupt after the last selected input transfers.
// - interrupt bit low never raises the scan interrupt.
// - count code N up to 1011 scans inputs 0..N; codes 1100-1111 start no scan from idle but flag status bit 1 if the interrupt bit is high.
// - each scan starts at input 0 and steps upward, each conversion then a transfer.
// - high result register shows the upper eight result bits; writes ignored.
// - result is high byte above low register bits 7 and 6.
// - result registers are invalid while a conversion runs.
// - result registers have no defined reset value.
// - low register bits 5..0 are reserved and undefined.
// - low result register is read only; writes change nothing.
// - after each transfer, convert the next higher input unless it was the last.
module asd_scan_dma (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // axi4-lite write address and data
  input  wire logic [13:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [13:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter side
  output logic             adc_start,
  output logic [3:0]       adc_input_sel,
  input  wire logic        adc_done,
  input  wire logic [9:0]  adc_result,
  // register file write port
  output logic             rf_we,
  output logic [11:0]      rf_addr,
  output logic [7:0]       rf_wdata,
  // interrupt
  output logic             irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  asd_pkg::asd_state_t st_q, st_d;
  logic [7:0]  ctrl_q;
  logic [6:0]  dest_q;
  logic [1:0]  stat_q, mask_q;
  logic [3:0]  inp_q, inp_d;
  logic [9:0]  res_q;
  logic        busy_q;
  // bus capture registers
  logic        aw_q, w_q;
  logic [13:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire [11:0] wr_idx    = awaddr_q[13:2];
  wire [11:0] rd_idx    = s_axi_araddr[13:2];
  wire        wr_go     = aw_q && w_q && !bvalid_q;
  wire        rd_go     = s_axi_arvalid && !rvalid_q;
  wire        wr_ctrl   = wr_go && wr_idx == asd_pkg::REG_SCAN_CTRL_IDX && wstrb_q[0];
  wire        wr_dest   = wr_go && wr_idx == asd_pkg::REG_DEST_ADDR_IDX && wstrb_q[0];
  wire        wr_mask   = wr_go && wr_idx == asd_pkg::REG_IRQ_MASK_IDX && wstrb_q[0];
  // result registers accept the write cycle but keep their bits
  wire        wr_ro     = wr_idx == asd_pkg::REG_RESULT_HIGH_IDX ||
                          wr_idx == asd_pkg::REG_RESULT_LOW_IDX;
  wire        wr_known  = wr_ro || wr_idx == asd_pkg::REG_SCAN_CTRL_IDX ||
                          wr_idx == asd_pkg::REG_DEST_ADDR_IDX ||
                          wr_idx == asd_pkg::REG_IRQ_MASK_IDX ||
                          wr_idx == asd_pkg::REG_IRQ_STATUS_IDX;
  wire        rd_stat   = rd_go && rd_idx == asd_pkg::REG_IRQ_STATUS_IDX;

  // readies drop while a response waits: one write and one read in flight
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    // result bits follow {high[7:0], low[7:6]}; low[5:0] read as zero
    if (rd_idx == asd_pkg::REG_RESULT_HIGH_IDX) begin
      rd_val = {24'h00_0000, res_q[9:2]};
    end else if (rd_idx == asd_pkg::REG_RESULT_LOW_IDX) begin
      rd_val = {24'h00_0000, res_q[1:0], 6'h00};
    end else if (rd_idx == asd_pkg::REG_SCAN_CTRL_IDX) begin
      rd_val = {24'h00_0000, ctrl_q};
    end else if (rd_idx == asd_pkg::REG_DEST_ADDR_IDX) begin
      rd_val = {25'h000_0000, dest_q};
    end else if (rd_idx == asd_pkg::REG_IRQ_STATUS_IDX) begin
      rd_val = {29'h0000_0000, busy_q, stat_q};
    end else if (rd_idx == asd_pkg::REG_IRQ_MASK_IDX) begin
      rd_val = {30'h0000_0000, mask_q};
    end else begin
      // unmapped indices answer with an error and zero data
      rd_ok  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // scan sequencer
  // ---------------------------------------------------------------
  // control fields, decoded once and shared by sequencer and status
  wire       en       = ctrl_q[asd_pkg::CTRL_EN_BIT];
  wire [3:0] cnt      = ctrl_q[asd_pkg::CTRL_CNT_LSB +: asd_pkg::CTRL_CNT_W];
  wire       cnt_ok   = cnt <= asd_pkg::CNT_MAX_CODE;
  wire       last_inp = inp_q == cnt;
  wire       scan_end = st_q == asd_pkg::ASD_XFER_LO && last_inp;
  wire       done_evt = scan_end && ctrl_q[asd_pkg::CTRL_IRQ_BIT];
  // a reserved count only flags status when interrupts are wanted, so a
  // channel with its interrupt bit low never pulls the interrupt line
  wire       bad_evt  = en && !cnt_ok && st_q == asd_pkg::ASD_IDLE &&
                        ctrl_q[asd_pkg::CTRL_IRQ_BIT];

  always_comb begin
    st_d  = st_q;
    inp_d = inp_q;
    case (st_q)
      asd_pkg::ASD_IDLE: begin
        // reserved count codes leave the channel idle
        if (en && cnt_ok) begin
          st_d  = asd_pkg::ASD_CONVERT;
          inp_d = 4'h0;
        end
      end
      asd_pkg::ASD_CONVERT: begin
        // no time limit: a slow converter simply holds the channel here
        if (adc_done) begin
          st_d = asd_pkg::ASD_XFER_HI;
        end
      end
      asd_pkg::ASD_XFER_HI: begin
        // high byte goes out first, the low byte in the next cycle
        st_d = asd_pkg::ASD_XFER_LO;
      end
      asd_pkg::ASD_XFER_LO: begin
        // wrap to input 0 for the continuous update
        st_d  = asd_pkg::ASD_CONVERT;
        inp_d = last_inp ? 4'h0 : inp_q + 4'h1;
      end
      default: begin
        st_d = asd_pkg::ASD_IDLE;
      end
    endcase
    if (!en) begin
      st_d  = asd_pkg::ASD_IDLE;
      inp_d = 4'h0;
    end
  end

  // converter start pulses one cycle on entry to a conversion
  assign adc_start     = st_q != asd_pkg::ASD_CONVERT && st_d == asd_pkg::ASD_CONVERT;
  assign adc_input_sel = inp_d;

  // register file writes: two bytes per input, base = dest << 5
  // a 32-byte window leaves room for all twelve inputs without wrapping
  wire [11:0] rf_base = {dest_q, 5'h00};
  wire [11:0] rf_off  = {7'h00, inp_q, st_q == asd_pkg::ASD_XFER_LO};
  assign rf_we    = st_q == asd_pkg::ASD_XFER_HI || st_q == asd_pkg::ASD_XFER_LO;
  assign rf_addr  = rf_base + rf_off;
  assign rf_wdata = st_q == asd_pkg::ASD_XFER_LO ? {res_q[1:0], 6'h00} : res_q[9:2];

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  // level output: stays high until software reads the status register
  assign irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // result capture has no reset: contents undefined until the first conversion
  // plain flops keep this cheap; software waits for the done flag instead
  always_ff @(posedge mclk) begin
    if (st_q == asd_pkg::ASD_CONVERT && adc_done) begin
      res_q <= adc_result;
    end
  end

  // sequencer state; a control write acts one cycle after it lands
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q   <= asd_pkg::ASD_IDLE;
      inp_q  <= 4'h0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      inp_q  <= inp_d;
      busy_q <= st_d == asd_pkg::ASD_CONVERT;
    end
  end

  // software registers; reserved control bits are dropped on write so
  // a careless write of ones cannot wake an undefined mode later
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= asd_pkg::CTRL_RESET;
      dest_q <= asd_pkg::DEST_RESET;
      mask_q <= asd_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0] & asd_pkg::CTRL_WMASK;
      end
      if (wr_dest) begin
        dest_q <= wdata_q[6:0];
      end
      if (wr_mask) begin
        mask_q <= wdata_q[1:0];
      end
    end
  end

  // sticky status, cleared by read; a new event beats the clear
  // so an event landing in the read cycle is never lost
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (rd_stat ? 2'h0 : stat_q) | {bad_evt, done_evt};
    end
  end

  // axi write channel capture and response
  // address and data may come in either order; each waits for the other
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 14'h0000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= asd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? asd_pkg::RESP_OKAY : asd_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read channel
  // read data is registered so it stands unchanged until rready
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= asd_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_ok ? asd_pkg::RESP_OKAY : asd_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// >>> test/asd_scan_dma_asserts.sv
`timescale 1ns/10ps
// watches converter, register-file and bus handshakes at the top ports
module asd_scan_dma_asserts (
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  // scan side
  input wire logic        adc_start,
  input wire logic [3:0]  adc_input_sel,
  input wire logic        adc_done,
  input wire logic        rf_we,
  input wire logic [11:0] rf_addr,
  input wire logic [7:0]  rf_wdata,
  input wire logic        irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [3:0] last_sel_q;
  // input of the previous start, so each new start can be tied to it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) last_sel_q <= 4'h0;
    else if (adc_start) last_sel_q <= adc_input_sel;
  end
  a_sel_in_range: assert property (adc_start |-> adc_input_sel <= 4'hB)
    else $error("start on a reserved input");
  a_step_up_one: assert property (adc_start && adc_input_sel != 4'h0
    |-> adc_input_sel == last_sel_q + 4'h1) else $error("input skipped");
  a_we_after_done: assert property ($rose(rf_we) |-> $past(adc_done))
    else $error("transfer without a finished conversion");
  a_byte_pair: assert property ($rose(rf_we) |=> rf_we &&
    rf_addr == $past(rf_addr) + 12'h1 ##1 !rf_we) else $error("byte pair broken");
  // the low byte shares its cycle with the next start, so use the held input
  a_addr_input: assert property (rf_we |-> rf_addr[4:1] == last_sel_q)
    else $error("address not from input");
  a_low_pad: assert property (rf_we && rf_addr[0] |-> rf_wdata[5:0] == 6'h00)
    else $error("low byte padding wrong");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer withdrawn");
  c_irq: cover property ($rose(irq));
  c_top_input: cover property (adc_start && adc_input_sel == 4'hB);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind asd_scan_dma asd_scan_dma_asserts u_asserts (.mclk, .resetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rresp, .adc_start, .adc_input_sel, .adc_done, .rf_we, .rf_addr, .rf_wdata, .irq);

// >>> test/asd_adc_model.sv
`timescale 1ns/10ps
// converter stand-in: one result per start, fast or slow, can be muted
module asd_adc_model (
  // clock, reset, controls
  input wire logic  mclk,
  input wire logic  resetn,
  input wire logic  adc_start,
  input wire logic  slow,
  input wire logic  mute,
  // result
  output logic       adc_done,
  output logic [9:0] adc_result
);
  int cnt = 0;
  // result bus toggles outside done so stale values never look valid
  always @(posedge mclk) begin
    adc_done <= 1'b0;
    adc_result <= resetn ? ~adc_result : 10'h000;
    if (!resetn || mute) cnt <= 0;
    else if (adc_start) cnt <= slow ? 9 : 1; // single-shot per start
    else if (cnt == 1) begin
      adc_done <= 1'b1;
      adc_result <= 10'($urandom);
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

// >>> test/adc_scan_dma_channel_tb.sv
`timescale 1ns/10ps
module adc_scan_dma_channel_tb;
  logic        mclk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, adc_start, adc_done, rf_we, irq, slow, mute;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb, adc_input_sel;
  logic [9:0]  adc_result, last;
  logic [11:0] rf_addr;
  logic [7:0]  rf_wdata;
  logic [6:0]  dest;
  logic [9:0]  rq[$];
  int          fails = 0, tests_run = 0, k = 0, n_sel = 0, starts = 0, s0;
  asd_scan_dma dut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_start, .adc_input_sel, .adc_done,
    .adc_result, .rf_we, .rf_addr, .rf_wdata, .irq);
  asd_adc_model m (.mclk, .resetn, .adc_start, .slow, .mute, .adc_done, .adc_result);
  always #5 mclk = ~mclk;
  function automatic logic [13:0] ra(input logic [11:0] x);
    return {x, 2'b00};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle; each channel released at the edge that takes it
  task automatic bus(input bit w, input logic [13:0] a, input logic [31:0] d);
    @(posedge mclk);
    if (w) begin
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    end
    // no cycle limit here: a hung slave is caught by the watchdog
    forever begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w && s_axi_bvalid) begin
        r = s_axi_bresp; s_axi_bready <= 1'b0; break;
      end
      if (!w && s_axi_rvalid) begin
        q = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; break;
      end
    end
  endtask
  // reference model: queue of results against each register-file byte
  always @(posedge mclk) begin
    if (adc_start) begin
      starts++;
      chk(adc_input_sel, ((k + 1) / 2) % (n_sel + 1));
    end
    if (adc_done) rq.push_back(adc_result);
    if (rf_we) begin
      chk(rf_addr, {dest, 5'h00} + 2 * ((k / 2) % (n_sel + 1)) + k % 2);
      if (k % 2 == 0) chk(rf_wdata, rq[0][9:2]);
      else begin
        chk(rf_wdata, {rq[0][1:0], 6'h00});
        last = rq.pop_front();
      end
      k++;
      if (k == 2 * (n_sel + 1)) mute <= 1'b1;
    end
  end
  // full scan of inputs 0..n, then stop, check interrupt and result registers
  task automatic scan(input int n, input bit ie);
    n_sel = n; k = 0; rq.delete();
    mute <= 1'b0; slow <= 1'($urandom);
    bus(1, ra(asd_pkg::REG_SCAN_CTRL_IDX), (ie ? 32'hC0 : 32'h80) | n);
    while (!mute) @(posedge mclk);
    repeat (2) @(posedge mclk);
    chk(irq, ie);
    bus(1, ra(asd_pkg::REG_SCAN_CTRL_IDX), 0);
    bus(0, ra(asd_pkg::REG_IRQ_STATUS_IDX), 0);
    chk(q, ie);
    bus(1, ra(asd_pkg::REG_RESULT_HIGH_IDX), $urandom);
    bus(1, ra(asd_pkg::REG_RESULT_LOW_IDX), $urandom);
    bus(0, ra(asd_pkg::REG_RESULT_HIGH_IDX), 0);
    chk(q, last[9:2]);
    bus(0, ra(asd_pkg::REG_RESULT_LOW_IDX), 0);
    chk(q, {last[1:0], 6'h00});
    chk(irq, 0);
    $display("scan test inputs 0..%0d done", n);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
  // main sequence
  initial begin
    {mclk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, slow, mute, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    dest = 7'h00;
    void'($urandom(37259));
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    bus(0, ra(asd_pkg::REG_SCAN_CTRL_IDX), 0);
    chk(q, asd_pkg::CTRL_RESET);
    bus(0, 14'h0400, 0);
    chk(r, asd_pkg::RESP_SLVERR);
    dest = 7'($urandom);
    bus(1, ra(asd_pkg::REG_DEST_ADDR_IDX), dest);
    bus(1, ra(asd_pkg::REG_IRQ_MASK_IDX), 1);
    scan(0, 1);
    scan(5, 0);
    scan(11, 1);
    scan($urandom % 12, 1);
    s0 = starts;
    bus(1, ra(asd_pkg::REG_IRQ_MASK_IDX), 3);
    for (int c = 12; c < 16; c++) begin
      bus(1, ra(asd_pkg::REG_SCAN_CTRL_IDX), 32'h80 | c);
      repeat (10) @(posedge mclk);
    end
    chk(starts, s0);
    chk(irq, 0);
    bus(1, ra(asd_pkg::REG_SCAN_CTRL_IDX), 32'hCC);
    repeat (2) @(posedge mclk);
    chk(irq, 1);
    bus(1, ra(asd_pkg::REG_SCAN_CTRL_IDX), 0);
    bus(0, ra(asd_pkg::REG_IRQ_STATUS_IDX), 0);
    chk(q, 2);
    chk(starts, s0);
    $display("reserved count test done");
    print_verdict();
  end
endmodule
